// file: design/acr_clk_div.sv
// Programmable divider producing the converter clock from the oscillator.
// Assumes the ratio is one of the four legal converter rates.
`timescale 1ns/10ps
module acr_clk_div (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Control
    input wire logic enable_in,
    input wire acr_pkg::acr_div_t rate_in,
    // Divided clock
    output logic conv_clk_out
);

    logic [6:0] ratio;
    logic [5:0] count_r;
    logic conv_clk_r;

    // Map rate code to the full division ratio
    always_comb begin
        unique case (rate_in)
            acr_pkg::ACR_DIV16: ratio = acr_pkg::DIV_16;
            acr_pkg::ACR_DIV4: ratio = acr_pkg::DIV_4;
            acr_pkg::ACR_DIV64: ratio = acr_pkg::DIV_64;
            acr_pkg::ACR_DIV8: ratio = acr_pkg::DIV_8;
        endcase
    end

    // Toggle every half ratio; stopped while the converter is powered down
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= 6'h00;
            conv_clk_r <= 1'b0;
        end else if (!enable_in) begin
            count_r <= 6'h00;
            conv_clk_r <= 1'b0;
        end else if (count_r >= ratio[6:1] - 6'h01) begin
            count_r <= 6'h00;
            conv_clk_r <= ~conv_clk_r;
        end else begin
            count_r <= count_r + 6'h01;
        end
    end

    assign conv_clk_out = conv_clk_r;

endmodule

// file: design/acr_pkg.sv
// Package for the converter control block: offsets, fields, resets, types.
// Assumes a 32-bit AHB-Lite slave port and a single 50 MHz clock.
package acr_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_PIN_EN = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_OFFCAL = 8'h08;
    localparam logic [7:0] OFS_RES_HI = 8'h0C;
    localparam logic [7:0] OFS_RES_LO = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_PIN_REQ = 8'h18;

    // Reset values
    localparam logic [7:0] RST_PIN_EN = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_OFFCAL = 8'h00;

    // Field masks for readable bits
    localparam logic [7:0] MASK_PIN_EN = 8'h7F;
    localparam logic [7:0] MASK_OFFCAL = 8'hF8;
    localparam logic [7:0] MASK_RES_LO = 8'h03;

    // Control register bit positions
    localparam int CTRL_REF = 7;
    localparam int CTRL_DIV_HI = 6;
    localparam int CTRL_DIV_LO = 5;
    localparam int CTRL_RUN = 4;
    localparam int CTRL_PWR = 3;
    localparam int CTRL_CH_HI = 2;
    localparam int CTRL_CH_LO = 0;

    // Offset calibration bit positions
    localparam int OFC_EN = 7;
    localparam int OFC_POS = 6;
    localparam int OFC_MAG_HI = 5;
    localparam int OFC_MAG_LO = 3;

    // Interrupt status: done flag position
    localparam int IRQ_DONE = 3;

    // Pin request bits in the arbitration register
    localparam int REQ_TIMER = 0;
    localparam int REQ_COMP_OUT = 1;
    localparam int REQ_OSC = 2;
    localparam int REQ_COMP_NEG = 3;

    // AHB constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

    // Divider ratios and the unused channel code
    localparam logic [6:0] DIV_16 = 7'h10;
    localparam logic [6:0] DIV_4 = 7'h04;
    localparam logic [6:0] DIV_64 = 7'h40;
    localparam logic [6:0] DIV_8 = 7'h08;
    localparam int UNUSED_CHANNEL = 7;

    // Converter clock rate codes
    typedef enum logic [1:0] {
        ACR_DIV16 = 2'b00,
        ACR_DIV4 = 2'b01,
        ACR_DIV64 = 2'b10,
        ACR_DIV8 = 2'b11
    } acr_div_t;

    // Function granted on a shared pin
    typedef enum logic [2:0] {
        ACR_FN_PORT = 3'b000,
        ACR_FN_ANALOG = 3'b001,
        ACR_FN_TIMER = 3'b010,
        ACR_FN_COMP_OUT = 3'b011,
        ACR_FN_OSC = 3'b100,
        ACR_FN_VREF = 3'b101,
        ACR_FN_COMP_NEG = 3'b110
    } acr_fn_t;

    // Signals to the converter macro
    typedef struct packed {
        logic [2:0] channel;
        logic conv_clk;
        logic power_on;
        logic start;
        logic ref_from_pin;
        logic cal_enable;
        logic cal_positive;
        logic [2:0] cal_magnitude;
    } acr_conv_req_t;

    // Answer from the converter macro
    typedef struct packed {
        logic [9:0] result;
        logic done;
    } acr_conv_rsp_t;

endpackage

// file: design/acr_top.sv
// Converter control block: registers, pin arbitration, converter handshake.
// Assumes an AHB-Lite master on the same clock and a converter macro that
// returns a one-cycle done strobe with the result.
`timescale 1ns/10ps
module acr_top (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Converter macro
    output acr_pkg::acr_conv_req_t conv_req_out,
    input wire acr_pkg::acr_conv_rsp_t conv_rsp_in,
    // Pin function grants
    output logic [6:0] pin_analog_out,
    output acr_pkg::acr_fn_t pin0_fn_out,
    output acr_pkg::acr_fn_t pin4_fn_out,
    output acr_pkg::acr_fn_t pin5_fn_out
);

    // Software registers
    logic [7:0] pin_en_r;
    logic [7:0] ctrl_r; // Control register as software sees it
    // One register per concern, so each has a single writing process
    logic [2:0] ref_rate_r; // Reference select and clock rate code
    logic pwr_r; // Converter power
    logic run_r; // Conversion in progress
    logic [2:0] chan_r; // Selected channel
    logic [7:0] offcal_r;
    logic [3:0] pin_req_r;
    logic [7:0] res_hi_r;
    logic [1:0] res_lo_r;
    logic done_flag_r;
    // Bus data phase capture
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic rd_ok;
    logic [31:0] rd_nxt;
    logic [31:0] hrdata_r;
    // Converter outputs
    acr_pkg::acr_conv_req_t conv_req_r;
    logic start_r;
    logic conv_clk;
    acr_pkg::acr_fn_t pin0_fn_nxt;
    acr_pkg::acr_fn_t pin4_fn_nxt;
    acr_pkg::acr_fn_t pin5_fn_nxt;
    acr_pkg::acr_fn_t pin0_fn_r;
    acr_pkg::acr_fn_t pin4_fn_r;
    acr_pkg::acr_fn_t pin5_fn_r;
    logic [6:0] pin_analog_r;
    logic wr_ctrl;
    logic wr_stat;
    logic done;

    // Address phase accepted for this slave
    function automatic logic phase_ok(input logic sel, input logic [1:0] tr,
                                      input logic rdy);
        phase_ok = sel && rdy && tr == acr_pkg::HTRANS_NONSEQ;
    endfunction

    assign done = conv_rsp_in.done;
    assign ctrl_r = {ref_rate_r, run_r, pwr_r, chan_r};
    assign wr_ctrl = wr_pend_r && wr_addr_r == acr_pkg::OFS_CTRL;
    assign wr_stat = wr_pend_r && wr_addr_r == acr_pkg::OFS_IRQ_STAT;
    assign rd_ok = phase_ok(hsel_in, htrans_in, hready_in) && !hwrite_in;

    // Capture write address; data follows in the next cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= phase_ok(hsel_in, htrans_in, hready_in) && hwrite_in;
            wr_addr_r <= haddr_in[7:0];
        end
    end

    // Read mux; values sampled at the address phase, zero when unmapped
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (haddr_in[7:0])
            acr_pkg::OFS_PIN_EN:
                rd_nxt[7:0] = pin_en_r & acr_pkg::MASK_PIN_EN;
            acr_pkg::OFS_CTRL: rd_nxt[7:0] = ctrl_r;
            acr_pkg::OFS_OFFCAL:
                rd_nxt[7:0] = offcal_r & acr_pkg::MASK_OFFCAL;
            acr_pkg::OFS_RES_HI: rd_nxt[7:0] = res_hi_r;
            acr_pkg::OFS_RES_LO: rd_nxt[1:0] = res_lo_r;
            acr_pkg::OFS_IRQ_STAT: rd_nxt[acr_pkg::IRQ_DONE] = done_flag_r;
            acr_pkg::OFS_PIN_REQ: rd_nxt[3:0] = pin_req_r;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data register; always ready, always OKAY
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_ok) begin
            hrdata_r <= rd_nxt;
        end
    end

    assign hrdata_out = hrdata_r;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    // Plain configuration registers
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_en_r <= acr_pkg::RST_PIN_EN;
            offcal_r <= acr_pkg::RST_OFFCAL;
            pin_req_r <= 4'h0;
        end else if (wr_pend_r) begin
            if (wr_addr_r == acr_pkg::OFS_PIN_EN) begin
                pin_en_r <= hwdata_in[7:0] & acr_pkg::MASK_PIN_EN;
            end
            if (wr_addr_r == acr_pkg::OFS_OFFCAL) begin
                offcal_r <= hwdata_in[7:0] & acr_pkg::MASK_OFFCAL;
            end
            if (wr_addr_r == acr_pkg::OFS_PIN_REQ) begin
                pin_req_r <= hwdata_in[3:0];
            end
        end
    end

    // Control register: reference, rate and power are plain fields
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ref_rate_r <= acr_pkg::RST_CTRL[7:5];
            pwr_r <= acr_pkg::RST_CTRL[acr_pkg::CTRL_PWR];
        end else if (wr_ctrl) begin
            ref_rate_r <= hwdata_in[7:5];
            pwr_r <= hwdata_in[acr_pkg::CTRL_PWR];
        end
    end

    // Run bit: set by software only, cleared by completion only
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_r <= acr_pkg::RST_CTRL[acr_pkg::CTRL_RUN];
        end else if (wr_ctrl && hwdata_in[acr_pkg::CTRL_RUN]) begin
            run_r <= 1'b1;
        end else if (done) begin
            run_r <= 1'b0;
        end
        // A written zero is ignored on purpose
    end

    // Channel select only while idle and no pending done
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chan_r <= acr_pkg::RST_CTRL[2:0];
        end else if (wr_ctrl && !done_flag_r &&
                     !ctrl_r[acr_pkg::CTRL_RUN]) begin
            chan_r <= hwdata_in[2:0];
        end
    end

    // Start pulse on a run write; an unpowered converter ignores it
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_r <= 1'b0;
        end else begin
            start_r <= wr_ctrl && hwdata_in[acr_pkg::CTRL_RUN] &&
                       !ctrl_r[acr_pkg::CTRL_RUN];
        end
    end

    // Result capture on the done strobe
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_hi_r <= 8'h00;
            res_lo_r <= 2'b00;
        end else if (done) begin
            res_hi_r <= conv_rsp_in.result[9:2];
            res_lo_r <= conv_rsp_in.result[1:0];
        end
    end

    // Done flag; a completion in the clearing cycle wins
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_flag_r <= 1'b0;
        end else if (done) begin
            done_flag_r <= 1'b1;
        end else if (wr_stat && !hwdata_in[acr_pkg::IRQ_DONE]) begin
            done_flag_r <= 1'b0;
        end
    end

    // Converter clock; idle while powered down to save power
    acr_clk_div u_div (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .enable_in(ctrl_r[acr_pkg::CTRL_PWR]),
        .rate_in(acr_pkg::acr_div_t'(ctrl_r[6:5])),
        .conv_clk_out(conv_clk)
    );

    // Registered drive of the converter macro
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_req_r <= '0;
        end else begin
            conv_req_r.channel <= ctrl_r[2:0];
            conv_req_r.conv_clk <= conv_clk;
            conv_req_r.power_on <= ctrl_r[acr_pkg::CTRL_PWR];
            conv_req_r.start <= start_r &&
                ctrl_r[2:0] != 3'(acr_pkg::UNUSED_CHANNEL);
            conv_req_r.ref_from_pin <= ctrl_r[acr_pkg::CTRL_REF];
            conv_req_r.cal_enable <= offcal_r[acr_pkg::OFC_EN];
            conv_req_r.cal_positive <= offcal_r[acr_pkg::OFC_POS];
            conv_req_r.cal_magnitude <=
                offcal_r[acr_pkg::OFC_MAG_HI:acr_pkg::OFC_MAG_LO];
        end
    end

    assign conv_req_out = conv_req_r;

    // Shared pin arbitration by fixed priority
    always_comb begin
        if (pin_req_r[acr_pkg::REQ_OSC]) begin
            pin0_fn_nxt = acr_pkg::ACR_FN_OSC;
        end else if (pin_en_r[0]) begin
            pin0_fn_nxt = acr_pkg::ACR_FN_ANALOG;
        end else begin
            pin0_fn_nxt = acr_pkg::ACR_FN_PORT;
        end
        if (ctrl_r[acr_pkg::CTRL_REF]) begin
            pin4_fn_nxt = acr_pkg::ACR_FN_VREF;
        end else if (pin_req_r[acr_pkg::REQ_COMP_NEG]) begin
            pin4_fn_nxt = acr_pkg::ACR_FN_COMP_NEG;
        end else if (pin_en_r[4]) begin
            pin4_fn_nxt = acr_pkg::ACR_FN_ANALOG;
        end else begin
            pin4_fn_nxt = acr_pkg::ACR_FN_PORT;
        end
        if (pin_req_r[acr_pkg::REQ_TIMER]) begin
            pin5_fn_nxt = acr_pkg::ACR_FN_TIMER;
        end else if (pin_req_r[acr_pkg::REQ_COMP_OUT]) begin
            pin5_fn_nxt = acr_pkg::ACR_FN_COMP_OUT;
        end else if (pin_en_r[5]) begin
            pin5_fn_nxt = acr_pkg::ACR_FN_ANALOG;
        end else begin
            pin5_fn_nxt = acr_pkg::ACR_FN_PORT;
        end
    end

    // Registered pin grants; analog mode only where granted
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin0_fn_r <= acr_pkg::ACR_FN_PORT;
            pin4_fn_r <= acr_pkg::ACR_FN_PORT;
            pin5_fn_r <= acr_pkg::ACR_FN_PORT;
            pin_analog_r <= 7'h00;
        end else begin
            pin0_fn_r <= pin0_fn_nxt;
            pin4_fn_r <= pin4_fn_nxt;
            pin5_fn_r <= pin5_fn_nxt;
            pin_analog_r <= pin_en_r[6:0];
            pin_analog_r[0] <= pin0_fn_nxt == acr_pkg::ACR_FN_ANALOG;
            pin_analog_r[4] <= pin4_fn_nxt == acr_pkg::ACR_FN_ANALOG;
            pin_analog_r[5] <= pin5_fn_nxt == acr_pkg::ACR_FN_ANALOG;
        end
    end

    assign pin0_fn_out = pin0_fn_r;
    assign pin4_fn_out = pin4_fn_r;
    assign pin5_fn_out = pin5_fn_r;
    assign pin_analog_out = pin_analog_r;

    // Completion clears run the next cycle
    a_run_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        done && !(wr_ctrl && hwdata_in[acr_pkg::CTRL_RUN])
        |=> !ctrl_r[acr_pkg::CTRL_RUN])
        else $error("run bit not cleared on done");
    // Done flag set after completion
    a_done_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        done |=> done_flag_r)
        else $error("done flag not set");
    // Run never falls without a completion
    a_run_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_r[acr_pkg::CTRL_RUN] && !done |=> ctrl_r[acr_pkg::CTRL_RUN])
        else $error("run bit cleared without completion");
    // Result captured from the macro
    a_result_load: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        done |=> {res_hi_r, res_lo_r} == $past(conv_rsp_in.result))
        else $error("result not loaded");
    // Channel frozen while busy
    a_chan_frozen: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (ctrl_r[acr_pkg::CTRL_RUN] || done_flag_r) |=> $stable(ctrl_r[2:0]))
        else $error("channel changed while busy");
    // Run write gives start two cycles later
    a_start_out: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        wr_ctrl && hwdata_in[acr_pkg::CTRL_RUN] && !ctrl_r[acr_pkg::CTRL_RUN]
        && ctrl_r[2:0] != 3'(acr_pkg::UNUSED_CHANNEL)
        && hwdata_in[2:0] != 3'(acr_pkg::UNUSED_CHANNEL)
        |=> ##1 conv_req_out.start)
        else $error("start pulse missing");
    // Reference pin outranks everything on bit 4
    a_pin4_vref: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ctrl_r[acr_pkg::CTRL_REF] |=> pin4_fn_out == acr_pkg::ACR_FN_VREF)
        else $error("reference not granted pin");
    // Timer outranks the rest on bit 5
    a_pin5_timer: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        pin_req_r[acr_pkg::REQ_TIMER] |=> pin5_fn_out == acr_pkg::ACR_FN_TIMER
        && !pin_analog_out[5])
        else $error("timer not granted pin");
    // Oscillator outranks analog on bit 0
    a_pin0_osc: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        pin_req_r[acr_pkg::REQ_OSC] |=> !pin_analog_out[0])
        else $error("oscillator pin in analog mode");

endmodule

// file: sim/acr_conv_model.sv
// Behavioural converter macro: answers a start pulse with a result.
// Assumes the control block's clock and its request struct.
`timescale 1ns/10ps
module acr_conv_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Bench controls: sample value and latency in cycles
    input wire logic [9:0] raw_in,
    input wire logic [7:0] delay_in,
    // Converter side
    input wire acr_pkg::acr_conv_req_t req_in,
    output acr_pkg::acr_conv_rsp_t rsp_out
);
    logic [7:0] cnt_r; // Cycles left in the conversion

    // Count down from start; result bus toggles while it is not valid,
    // so a block that latches it early sees garbage, not a lucky value
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 8'h00;
            rsp_out <= '0;
        end else begin
            rsp_out.done <= 1'b0;
            rsp_out.result <= ~rsp_out.result;
            // Only a powered converter accepts a start
            if (req_in.start && req_in.power_on) begin
                cnt_r <= delay_in;
            end else if (cnt_r == 8'h01) begin
                cnt_r <= 8'h00;
                rsp_out.done <= 1'b1;
                rsp_out.result <= raw_in;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule

// file: sim/acr_top_tb.sv
// Self-checking bench for the converter control block.
// Assumes one 50 MHz clock and the behavioural converter model.
`timescale 1ns/10ps
module acr_top_tb;
    logic clock_in, rst_n_in, hsel, hwrite, hready, hresp, rd_dp;
    logic [31:0] haddr, hwdata, hrdata, seed, v, ch;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [6:0] pin_an;
    logic [9:0] raw;
    logic [7:0] dly;
    acr_pkg::acr_conv_req_t req;
    acr_pkg::acr_conv_rsp_t rsp;
    acr_pkg::acr_fn_t fn0, fn4, fn5, e0, e4, e5;
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    int error_cnt, total_checks, cycles, starts, n, per;

    acr_top i_acr_top (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .conv_req_out(req),
        .conv_rsp_in(rsp), .pin_analog_out(pin_an), .pin0_fn_out(fn0),
        .pin4_fn_out(fn4), .pin5_fn_out(fn5));
    acr_conv_model i_acr_conv_model (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .raw_in(raw), .delay_in(dly),
        .req_in(req), .rsp_out(rsp));

    // Free-running 50 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    // Xorshift source, fixed seed
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // One comparison, counted; mismatches reported at once
    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Single AHB-Lite transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0000_00, a};
        htrans <= acr_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= acr_pkg::HSIZE_WORD;
        @(posedge clock_in);
        while (hready !== 1'b1) @(posedge clock_in);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clock_in);
        while (hready !== 1'b1) @(posedge clock_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // The expectation is queued; the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Rising edges of the converter clock, period from the 2nd to 3rd
    task automatic measure(output int p);
        int t0, r, k;
        logic q;
        p = 0;
        t0 = 0;
        r = 0;
        q = req.conv_clk;
        for (k = 0; k < 250; k++) begin
            @(posedge clock_in);
            if (req.conv_clk === 1'b1 && q !== 1'b1) begin
                r++;
                if (r == 3) p = k - t0;
                t0 = k;
            end
            q = req.conv_clk;
        end
    endtask

    // Monitor: read data at the end of each read data phase, start
    // pulses, and the hang limit
    always @(posedge clock_in) begin
        if (rd_dp === 1'b1 && hready === 1'b1) begin
            check("hrdata", exp_q.pop_front(), hrdata);
            check("hresp", 32'h0, 32'(hresp));
        end
        if (hready === 1'b1) begin
            rd_dp <= hsel && htrans == acr_pkg::HTRANS_NONSEQ && !hwrite;
        end
        if (req.start === 1'b1) starts++;
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        seed = 32'h0000_22E6;
        {hsel, hwrite, rd_dp, haddr, hwdata, htrans, hsize} = '0;
        raw = 10'h000;
        dly = 8'h28;
        rst_n_in = 1'b0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        // Reset values and an unmapped place
        rd(acr_pkg::OFS_PIN_EN, 32'h0);
        rd(acr_pkg::OFS_CTRL, 32'h0);
        rd(acr_pkg::OFS_IRQ_STAT, 32'h0);
        wr(8'h1C, rnd());
        rd(8'h1C, 32'h0);
        // Every request set against random enables and both references
        for (int k = 0; k < 32; k++) begin
            v = rnd();
            wr(acr_pkg::OFS_PIN_EN, v);
            wr(acr_pkg::OFS_PIN_REQ, 32'(k[3:0]));
            wr(acr_pkg::OFS_CTRL, {24'h0, k[4], 7'h00});
            rd(acr_pkg::OFS_PIN_EN, v & 32'h7F);
            repeat (2) @(posedge clock_in);
            e0 = k[2] ? acr_pkg::ACR_FN_OSC :
                 v[0] ? acr_pkg::ACR_FN_ANALOG : acr_pkg::ACR_FN_PORT;
            e4 = k[4] ? acr_pkg::ACR_FN_VREF :
                 k[3] ? acr_pkg::ACR_FN_COMP_NEG :
                 v[4] ? acr_pkg::ACR_FN_ANALOG : acr_pkg::ACR_FN_PORT;
            e5 = k[0] ? acr_pkg::ACR_FN_TIMER :
                 k[1] ? acr_pkg::ACR_FN_COMP_OUT :
                 v[5] ? acr_pkg::ACR_FN_ANALOG : acr_pkg::ACR_FN_PORT;
            check("pin0 fn", 32'(e0), 32'(fn0));
            check("pin4 fn", 32'(e4), 32'(fn4));
            check("pin5 fn", 32'(e5), 32'(fn5));
            check("ref sel", 32'(k[4]), 32'(req.ref_from_pin));
            check("analog", 32'({v[6], e5 == acr_pkg::ACR_FN_ANALOG,
                e4 == acr_pkg::ACR_FN_ANALOG, v[3:1],
                e0 == acr_pkg::ACR_FN_ANALOG}), 32'(pin_an));
        end
        wr(acr_pkg::OFS_PIN_REQ, 32'h0);
        // Offset settings: every magnitude, random enable and sign
        for (int k = 0; k < 8; k++) begin
            v = rnd();
            v = {24'h0, v[7:6], k[2:0], v[2:0]};
            wr(acr_pkg::OFS_OFFCAL, v);
            rd(acr_pkg::OFS_OFFCAL, v & 32'hF8);
            check("cal", v >> 3, 32'({req.cal_enable, req.cal_positive,
                req.cal_magnitude}));
        end
        // Each rate code, then power off stops the converter clock
        for (int k = 0; k < 4; k++) begin
            wr(acr_pkg::OFS_CTRL, {25'h0, k[1:0], 5'h08});
            measure(per);
            v = k == 0 ? 16 : k == 1 ? 4 : k == 2 ? 64 : 8;
            check("divider", v, 32'(per));
        end
        wr(acr_pkg::OFS_CTRL, 32'h0);
        measure(per);
        check("clk off", 32'h0, 32'(per));
        check("power", 32'h0, 32'(req.power_on));
        // Long conversion with writes made in mid-run
        // Codes 0 to 5 only, so that ch ^ 1 never reaches the unused code
        ch = rnd() % 6;
        v = rnd();
        raw = v[9:0];
        wr(acr_pkg::OFS_CTRL, 32'h08 | ch);
        n = starts;
        wr(acr_pkg::OFS_CTRL, 32'h18 | ch);
        wr(acr_pkg::OFS_CTRL, 32'h08 | (ch ^ 1));
        rd(acr_pkg::OFS_CTRL, 32'h18 | ch);
        check("start", 32'(n + 1), 32'(starts));
        check("channel", ch, 32'(req.channel));
        for (n = 0; n < 100 && rsp.done !== 1'b1; n++) @(posedge clock_in);
        rd(acr_pkg::OFS_RES_HI, 32'(raw[9:2]));
        rd(acr_pkg::OFS_RES_LO, 32'(raw[1:0]));
        rd(acr_pkg::OFS_CTRL, 32'h08 | ch);
        rd(acr_pkg::OFS_IRQ_STAT, 32'h08);
        wr(acr_pkg::OFS_CTRL, 32'h08 | (ch ^ 1));
        rd(acr_pkg::OFS_CTRL, 32'h08 | ch);
        wr(acr_pkg::OFS_IRQ_STAT, 32'h0);
        rd(acr_pkg::OFS_IRQ_STAT, 32'h0);
        // Prompt conversion right after a channel change
        dly = 8'h01;
        v = rnd();
        raw = v[9:0];
        wr(acr_pkg::OFS_CTRL, 32'h08 | (ch ^ 1));
        wr(acr_pkg::OFS_CTRL, 32'h18 | (ch ^ 1));
        repeat (6) @(posedge clock_in);
        rd(acr_pkg::OFS_RES_HI, 32'(raw[9:2]));
        rd(acr_pkg::OFS_CTRL, 32'h08 | (ch ^ 1));
        wr(acr_pkg::OFS_IRQ_STAT, 32'h0);
        // The unused channel code never starts the converter
        n = starts;
        wr(acr_pkg::OFS_CTRL, 32'h0F);
        wr(acr_pkg::OFS_CTRL, 32'h1F);
        repeat (6) @(posedge clock_in);
        check("no start", 32'(n), 32'(starts));
        repeat (2) @(posedge clock_in);
        end_of_test();
    end
endmodule
